/* ibmu_unit.sv */
// indirect bit move and block word move datapath
`timescale 1ns/10ps
module ibmu_unit #(
  parameter int WORD_W = ibmu_pkg::IBMU_WORD_W,
  parameter int ADDR_W = ibmu_pkg::IBMU_ADDR_W
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_resetn,
  input  wire logic                     i_enable,          // rung input from sequencer
  input  wire logic                     i_start,           // one-cycle pulse, operands valid
  input  wire ibmu_pkg::ibmu_op_t       i_op,
  input  wire ibmu_pkg::ibmu_kind_t     i_src_kind,
  input  wire logic [ADDR_W-1:0]        i_source_base,
  input  wire logic                     i_src_off_used,
  input  wire logic [WORD_W-1:0]        i_source_offset,   // value or timer/counter current value
  input  wire ibmu_pkg::ibmu_kind_t     i_dst_kind,
  input  wire logic [ADDR_W-1:0]        i_destination_base,
  input  wire logic                     i_dst_off_used,
  input  wire logic [WORD_W-1:0]        i_destination_offset,
  input  wire logic [6:0]               i_repeat_count,    // 0 means no repeat
  input  wire logic [WORD_W-1:0]        i_word_count,      // block move N
  input  wire logic                     i_word_shift_busy, // word shift in progress elsewhere
  input  wire logic                     i_flag_retained,   // retained flag value read at power-up
  input  wire logic                     i_flag_restore,    // one-cycle pulse after reset to load it
  input  wire logic                     i_err_clear,
  input  wire logic [WORD_W-1:0]        i_rd_data,         // operand memory read data, one cycle latency
  output logic                          o_rd_en,
  output logic [ADDR_W-1:0]             o_rd_addr,
  output logic                          o_rd_is_bit,
  output logic                          o_wr_en,
  output logic [ADDR_W-1:0]             o_wr_addr,
  output logic                          o_wr_is_bit,
  output logic [WORD_W-1:0]             o_wr_data,         // bit moves place the bit in [0]
  output logic                          o_busy,
  output logic                          o_done,
  output logic                          o_move_executing_flag,
  output logic                          o_program_error_flag,
  output logic                          o_err_lamp
);
  import ibmu_pkg::*;

  // latch state gives the one-cycle read latency a home, so write data can come from a flip-flop
  typedef enum logic [1:0] {IBMU_S_IDLE, IBMU_S_READ, IBMU_S_LATCH, IBMU_S_WRITE} ibmu_state_t;

  // bit address advance: plain addition for every kind; octal areas get no 3-bit low field skip
  function automatic logic [ADDR_W-1:0] ibmu_bit_add(input ibmu_kind_t k, input logic [ADDR_W-1:0] b,
                                                     input logic [ADDR_W-1:0] n);
    logic [ADDR_W-1:0] r;
    r = '0;
    if (k == IBMU_K_DATA) begin
      r = b + n; // bit index counted as word*16 + bit
    end else begin
      r = b + n; // bits held as plain count; octal label only at the boundary
    end
    return r;
  endfunction : ibmu_bit_add

  // range check per operand kind
  function automatic logic ibmu_bad(input ibmu_kind_t k, input logic [ADDR_W-1:0] a, input logic is_dst);
    logic b;
    b = 1'b0;
    if (k == IBMU_K_TIMER || k == IBMU_K_COUNTER) begin
      b = 1'b1; // not accepted as a bit base
    end else if (k == IBMU_K_CONST) begin
      b = is_dst || (a > ADDR_W'(1)); // constant base only 0 or 1
    end else if (k == IBMU_K_DATA) begin
      b = (a[ADDR_W-1:4] > IBMU_WORD_MAX[ADDR_W-5:0]);
    end else if (is_dst && (k == IBMU_K_INPUT)) begin
      b = 1'b1;
    end else if (is_dst && (k == IBMU_K_RELAY)) begin
      b = (a > IBMU_RELAY_MAX); // special relays refused
    end else begin
      b = (a > IBMU_BIT_MAX);
    end
    return b;
  endfunction : ibmu_bad

  ibmu_state_t        state_q;
  ibmu_op_t           op_q;
  ibmu_kind_t         skind_q, dkind_q;
  logic [ADDR_W-1:0]  src_q, dst_q;
  logic [WORD_W-1:0]  left_q;
  logic               move_flag_q, err_q, done_q;
  logic [ADDR_W-1:0]  src_first, dst_first, src_last, dst_last, span;
  logic               is_bit_op, bad_start;

  // first and last addresses; missing offset adds nothing
  always_comb begin
    is_bit_op = (i_op == IBMU_OP_BIT_MOVE) || (i_op == IBMU_OP_BIT_MOVE_INV);
    src_first = ibmu_bit_add(i_src_kind, i_source_base,
                             i_src_off_used ? ADDR_W'(i_source_offset) : '0);
    dst_first = ibmu_bit_add(i_dst_kind, i_destination_base,
                             i_dst_off_used ? ADDR_W'(i_destination_offset) : '0);
    if (is_bit_op) begin
      span = (i_repeat_count == '0) ? '0 : ADDR_W'(i_repeat_count - IBMU_REP_ONE);
    end else begin
      span = (i_word_count == '0) ? '0 : ADDR_W'(i_word_count - WORD_W'(1));
    end
    src_last = is_bit_op ? src_first + span : i_source_base + span;
    dst_last = is_bit_op ? dst_first + span : i_destination_base + span;
    if (is_bit_op) begin
      bad_start = ibmu_bad(i_src_kind, src_first, 1'b0) || ibmu_bad(i_src_kind, src_last, 1'b0) ||
                  ibmu_bad(i_dst_kind, dst_first, 1'b1) || ibmu_bad(i_dst_kind, dst_last, 1'b1) ||
                  (i_repeat_count > IBMU_REP_MAX);
    end else begin
      bad_start = (src_last > IBMU_WORD_MAX) || (dst_last > IBMU_WORD_MAX);
    end
  end

  // sequencer: read one unit, write one unit, repeat; starts only while enabled
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_q <= IBMU_S_IDLE;
      op_q    <= IBMU_OP_NONE;
      skind_q <= IBMU_K_INPUT;
      dkind_q <= IBMU_K_INPUT;
      src_q   <= '0;
      dst_q   <= '0;
      left_q  <= '0;
    end else begin
      case (state_q)
        IBMU_S_IDLE: begin
          if (i_start && i_enable && (i_op != IBMU_OP_NONE) && !bad_start) begin
            op_q    <= i_op;
            skind_q <= i_src_kind;
            dkind_q <= i_dst_kind;
            src_q   <= is_bit_op ? src_first : i_source_base;
            dst_q   <= is_bit_op ? dst_first : i_destination_base;
            left_q  <= WORD_W'(span);
            state_q <= ((!is_bit_op) && (i_word_count == '0)) ? IBMU_S_IDLE : IBMU_S_READ;
          end
        end
        IBMU_S_READ: begin
          state_q <= IBMU_S_LATCH;
        end
        // read data stands now; it is registered into the write word at this edge
        IBMU_S_LATCH: begin
          state_q <= IBMU_S_WRITE;
        end
        IBMU_S_WRITE: begin
          if (left_q == '0) begin
            state_q <= IBMU_S_IDLE;
          end else begin
            left_q  <= left_q - WORD_W'(1);
            src_q   <= src_q + ADDR_W'(1); // next consecutive bit or word
            dst_q   <= dst_q + ADDR_W'(1);
            state_q <= IBMU_S_READ;
          end
        end
        default: state_q <= IBMU_S_IDLE;
      endcase
    end
  end

  // memory strobes; word operands of any kind occupy one word location
  assign o_rd_en     = (state_q == IBMU_S_READ);
  assign o_rd_addr   = src_q;
  assign o_rd_is_bit = (op_q != IBMU_OP_BLOCK_MOVE);
  assign o_wr_en     = (state_q == IBMU_S_WRITE);
  assign o_wr_addr   = dst_q;
  assign o_wr_is_bit = (op_q != IBMU_OP_BLOCK_MOVE);
  assign o_busy      = (state_q != IBMU_S_IDLE);

  // bit data path: rd data bit 0 is the addressed bit
  logic [WORD_W-1:0] wdata_d;
  always_comb begin
    wdata_d = i_rd_data;
    if (op_q == IBMU_OP_BIT_MOVE_INV) begin
      wdata_d = {{(WORD_W-1){1'b0}}, ~i_rd_data[0]};
    end else if (op_q == IBMU_OP_BIT_MOVE) begin
      wdata_d = {{(WORD_W-1){1'b0}}, i_rd_data[0]};
    end
  end

  // write data: whole word, or one bit, inverted for the inverting move
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_wr_data <= '0;
    end else if (state_q == IBMU_S_LATCH) begin
      o_wr_data <= wdata_d; // stands through the write cycle that follows
    end
  end

  // done pulse in the cycle after the final write
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == IBMU_S_WRITE) && (left_q == '0);
    end
  end
  assign o_done = done_q;

  // word shift end seen as a falling busy level; same clock, so no synchroniser
  logic shift_busy_q;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      shift_busy_q <= 1'b0;
    end else begin
      shift_busy_q <= i_word_shift_busy;
    end
  end

  logic blk_active, blk_last;
  assign blk_active = (state_q != IBMU_S_IDLE) && (op_q == IBMU_OP_BLOCK_MOVE);
  assign blk_last   = blk_active && (state_q == IBMU_S_WRITE) && (left_q == '0);

  // executing flag; retained copy reloaded after power-up and held until a block move or shift ends
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      move_flag_q <= 1'b0;
    end else if (i_flag_restore) begin
      move_flag_q <= i_flag_retained;
    end else if (i_word_shift_busy || (blk_active && !blk_last)) begin
      move_flag_q <= 1'b1;
    end else if (blk_last || (shift_busy_q && !i_word_shift_busy)) begin
      move_flag_q <= 1'b0;
    end
  end
  assign o_move_executing_flag = move_flag_q;

  // error flag is sticky; a new error beats a clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      err_q <= 1'b0;
    end else if (i_start && i_enable && (i_op != IBMU_OP_NONE) && bad_start) begin
      err_q <= 1'b1;
    end else if (i_err_clear) begin
      err_q <= 1'b0;
    end
  end
  assign o_program_error_flag = err_q;
  assign o_err_lamp           = err_q;

  // one unit: read strobe, a gap while the data lands, then the write strobe
  sequence s_unit_gap;
    !o_rd_en && !o_wr_en;
  endsequence
  sequence s_unit_write;
    o_wr_en && !o_rd_en;
  endsequence

  a_flag_tracks_move: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_q == IBMU_S_READ && op_q == IBMU_OP_BLOCK_MOVE && !i_flag_restore) |=> o_move_executing_flag)
    else $error("executing flag not set during block move");
  a_err_on_bad: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_start && i_enable && i_op != IBMU_OP_NONE && bad_start) |=> (o_program_error_flag && !o_busy))
    else $error("bad address not flagged");
  a_idle_no_enable: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_q == IBMU_S_IDLE && !i_enable) |=> (state_q == IBMU_S_IDLE))
    else $error("move started without enable");
  a_read_pairs_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_rd_en |=> s_unit_gap ##1 s_unit_write)
    else $error("read strobe not followed by its write");
  a_inv_bit_data: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_q == IBMU_S_LATCH && op_q == IBMU_OP_BIT_MOVE_INV) |=>
    (o_wr_data == (($past(i_rd_data) & WORD_W'(1)) ^ WORD_W'(1))))
    else $error("inverted bit move wrote wrong data");
  a_flag_retained_holds: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_move_executing_flag && !o_busy && !i_word_shift_busy && !shift_busy_q && !i_flag_restore) |=>
    o_move_executing_flag)
    else $error("executing flag dropped while idle");
  a_done_ends_move: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_wr_en && left_q == '0) |=> (o_done && !o_busy))
    else $error("last write not followed by done");
endmodule : ibmu_unit

/* ibmu_pkg.sv */
// constants and types for the indirect bit move unit
package ibmu_pkg;
  // operand kinds as supplied by the sequencer
  typedef enum logic [2:0] {
    IBMU_K_INPUT, IBMU_K_OUTPUT, IBMU_K_RELAY, IBMU_K_SHIFT,
    IBMU_K_TIMER, IBMU_K_COUNTER, IBMU_K_DATA, IBMU_K_CONST
  } ibmu_kind_t;
  // operation select
  typedef enum logic [1:0] {
    IBMU_OP_NONE, IBMU_OP_BLOCK_MOVE, IBMU_OP_BIT_MOVE, IBMU_OP_BIT_MOVE_INV
  } ibmu_op_t;
  localparam int          IBMU_WORD_W      = 16;
  localparam int          IBMU_ADDR_W      = 17;
  localparam int          IBMU_OCT_W       = 3;
  localparam logic [16:0] IBMU_RELAY_MAX   = 17'h009FF; // last ordinary relay bit (160 words x 16 bits)
  localparam logic [16:0] IBMU_BIT_MAX     = 17'h01FFF; // last bit of any bit area
  localparam logic [16:0] IBMU_WORD_MAX    = 17'h0BB7F; // last word-type operand
  localparam logic [6:0]  IBMU_REP_MAX     = 7'h63;
  localparam logic [6:0]  IBMU_REP_ONE     = 7'h01;
  localparam logic [3:0]  IBMU_BIT_IN_REG  = 4'hF;
endpackage : ibmu_pkg

/* ibmu_mem_model.sv */
// operand memory model answering reads one cycle late
`timescale 1ns/10ps
module ibmu_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rd_en,
  input  wire logic [16:0] i_rd_addr,
  output logic      [15:0] o_rd_data
);
  initial o_rd_data = 16'h0F0F;
  // data only in the cycle after a read; otherwise it toggles so stale data never looks valid
  always @(posedge i_clk) begin
    o_rd_data <= i_rd_en ? (i_rd_addr[15:0] ^ 16'hA5C3) : ~o_rd_data;
  end
endmodule : ibmu_mem_model

/* indirect_bit_move_unit_test.sv */
// self-checking bench for the indirect bit move unit
`timescale 1ns/10ps
module indirect_bit_move_unit_test;
  import ibmu_pkg::*;
  localparam logic [15:0] MEM_MASK = 16'hA5C3; // the memory model answers address xor this word
  logic        clk = 0, resetn = 0, en = 0, start = 0, sou = 0, dou = 0;
  logic        restore = 0, retained = 0, eclr = 0, wsb = 0;
  ibmu_op_t    op = IBMU_OP_NONE;
  ibmu_kind_t  sk = IBMU_K_RELAY, dk = IBMU_K_RELAY;
  logic [16:0] sb = '0, db = '0, rd_addr, wr_addr;
  logic [15:0] so = '0, dof = '0, wn = '0, rd_data, wr_data;
  logic [6:0]  repeat_count = '0;
  logic        rd_en, rd_bit, wr_en, wr_bit, busy, done, mflag, eflag, lamp;
  logic [31:0] seed = 32'h454F9B61;
  logic [17:0] rdq[$], wrq[$];
  logic [15:0] wdq[$];
  int          mismatches = 0, cmp_count = 0, n;
  always #12.5 clk = ~clk;
  ibmu_unit u_dut (.i_clk(clk), .i_resetn(resetn), .i_enable(en), .i_start(start), .i_op(op),
    .i_src_kind(sk), .i_source_base(sb), .i_src_off_used(sou), .i_source_offset(so),
    .i_dst_kind(dk), .i_destination_base(db), .i_dst_off_used(dou), .i_destination_offset(dof),
    .i_repeat_count(repeat_count), .i_word_count(wn), .i_word_shift_busy(wsb), .i_flag_retained(retained),
    .i_flag_restore(restore), .i_err_clear(eclr), .i_rd_data(rd_data), .o_rd_en(rd_en),
    .o_rd_addr(rd_addr), .o_rd_is_bit(rd_bit), .o_wr_en(wr_en), .o_wr_addr(wr_addr),
    .o_wr_is_bit(wr_bit), .o_wr_data(wr_data), .o_busy(busy), .o_done(done),
    .o_move_executing_flag(mflag), .o_program_error_flag(eflag), .o_err_lamp(lamp));
  ibmu_mem_model u_mem (.i_clk(clk), .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data));
  // strobes are combinational, so they are captured mid-cycle, away from the edge
  always @(negedge clk) begin
    if (rd_en === 1'b1) rdq.push_back({rd_bit, rd_addr});
    if (wr_en === 1'b1) wrq.push_back({wr_bit, wr_addr});
    if (wr_en === 1'b1) wdq.push_back(wr_data);
    if (wr_en === 1'b1 && op == IBMU_OP_BLOCK_MOVE) chk(mflag, 1);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [16:0] xaddr(input logic [16:0] b, input logic u, input logic [15:0] o,
                                        input int k);
    return b + (u ? {1'b0, o} : 17'h0) + 17'(k);
  endfunction : xaddr
  // expected write word: whole word for block moves, else bit 0 of the word read, inverted for the inverting move
  function automatic logic [15:0] xdata(input logic [16:0] a);
    logic [15:0] w;
    w = a[15:0] ^ MEM_MASK;
    if (op == IBMU_OP_BLOCK_MOVE) return w;
    return {15'h0, w[0] ^ (op == IBMU_OP_BIT_MOVE_INV)};
  endfunction : xdata
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : tick
  task automatic rst;
    resetn = 0;
    tick(5);
    resetn = 1;
    tick(1);
  endtask : rst
  // one operation; expected addresses worked out from base plus optional offset plus unit
  task automatic go(input logic bo);
    int k, units;
    rdq = {};
    wrq = {};
    wdq = {};
    start = 1;
    tick(1);
    start = 0;
    for (k = 0; k < 1000 && done !== 1'b1; k++) tick(1);
    chk(done, 1);
    units = (op == IBMU_OP_BLOCK_MOVE) ? int'(wn) : ((repeat_count == 0) ? 1 : int'(repeat_count));
    chk(rdq.size(), units);
    chk(wrq.size(), units);
    chk(wdq.size(), units);
    for (k = 0; k < units && k < rdq.size() && k < wrq.size() && k < wdq.size(); k++) begin
      chk(rdq[k], {bo, xaddr(sb, sou, so, k)});
      chk(wrq[k], {bo, xaddr(db, dou, dof, k)});
      chk(wdq[k], xdata(xaddr(sb, sou, so, k)));
    end
  endtask : go
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    #(25ns * 20000);
    mismatches++;
    results;
  end
  initial begin
    rst;
    chk({busy, done, mflag, eflag, lamp, rd_en, wr_en}, 0);
    en = 1;
    sk = IBMU_K_RELAY;
    // random bit moves over relay/output areas, repeat 0, 1 and 99 as corners
    for (n = 0; n < 12; n++) begin
      seed = lfsr(seed);
      op = seed[0] ? IBMU_OP_BIT_MOVE_INV : IBMU_OP_BIT_MOVE;
      dk = seed[1] ? IBMU_K_OUTPUT : IBMU_K_RELAY;
      sb = {9'h0, seed[9:2]};
      db = {9'h0, seed[17:10]};
      so = {11'h0, seed[22:18]};
      dof = {11'h0, seed[27:23]};
      sou = seed[28];
      dou = seed[29];
      repeat_count = (n < 2) ? 7'(n) : ((n == 2) ? IBMU_REP_MAX : {5'h0, seed[31:30]});
      go(1'b1);
    end
    $display("done: random bit moves");
    sk = IBMU_K_DATA;
    dk = IBMU_K_DATA;
    {sb, db, sou, dou, so, dof, repeat_count} = {17'h000A5, 17'h00140, 2'b11, 16'h0000, 16'h000C, 7'h03};
    go(1'b1);
    $display("done: register bit move");
    en = 0;
    rdq = {};
    start = 1;
    tick(1);
    start = 0;
    tick(4);
    chk(rdq.size(), 0);
    $display("done: enable off");
    en = 1;
    sk = IBMU_K_RELAY;
    dk = IBMU_K_RELAY;
    {sb, sou, db, dou, dof, repeat_count} = {17'h00000, 1'b0, IBMU_RELAY_MAX, 1'b1, 16'h0001, 7'h00};
    wrq = {};
    start = 1;
    tick(1);
    start = 0;
    tick(5);
    chk({eflag, lamp}, 2'b11);
    chk(wrq.size(), 0);
    eclr = 1;
    tick(1);
    eclr = 0;
    tick(1);
    chk(eflag, 0);
    $display("done: address error");
    rst;
    retained = 1;
    restore = 1;
    tick(1);
    restore = 0;
    tick(1);
    chk(mflag, 1);
    op = IBMU_OP_BLOCK_MOVE;
    sk = IBMU_K_DATA;
    dk = IBMU_K_DATA;
    {sb, db, sou, dou, wn} = {17'h0000A, 17'h00014, 2'b00, 16'h0005};
    go(1'b0);
    tick(1);
    chk({mflag, busy}, 0);
    $display("done: block move and flag");
    // word shift elsewhere raises the flag while busy and drops it when it ends
    wsb = 1;
    tick(1);
    chk(mflag, 1);
    wsb = 0;
    tick(1);
    chk(mflag, 0);
    $display("done: word shift flag");
    results;
  end
endmodule : indirect_bit_move_unit_test
